// >>> src/msse_pkg.sv
// Constants, types and register map for the halt/store/subtract/swap executor
// Behaviour
// - Halt clears watchdog counter and watchdog prescaler to zero.
// - Halt sets timeout flag to 1, clears powerdown flag, enters halt mode.
// - Special page store copies accumulator into SFR index 0..31, flags kept.
// - Register minus accumulator, register 0..127, updates zero, digit carry, carry.
// - Subtract result goes to accumulator when dest bit 0, register when 1.
// - Nibble swap exchanges low and high nibbles, dest bit selects target, flags kept.
package msse_pkg;
    // APB register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ACCUM = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_WATCHDOG = 8'h0c;
    localparam logic [7:0] REG_FILE_BASE = 8'h80;
    localparam logic [7:0] REG_SFR_BASE = 8'hc0;
    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DEST_BIT = 16;
    // Status word bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT_CARRY = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_POWERDOWN_N = 3;
    localparam int ST_TIMEOUT_N = 4;
    localparam int ST_HALT = 5;
    // Reset values
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
    localparam logic [7:0] SFR_RST = 8'h00;
    // Opcode encodings
    localparam logic [7:0] OP_HALT = 8'h01;
    localparam logic [7:0] OP_SFR_STORE = 8'h02;
    localparam logic [7:0] OP_SUB = 8'h03;
    localparam logic [7:0] OP_SWAP = 8'h04;
    localparam logic [7:0] OP_WAKE = 8'h05;
    // Sizes
    localparam int FILE_DEPTH = 128;
    localparam int SFR_DEPTH = 32;
    // Executor states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_SLEEP = 3'b100
    } msse_state_t;
endpackage

// >>> src/msse_alu.sv
// Subtract and nibble-swap datapath
`timescale 1ns/100ps
module msse_alu (
    input wire logic [7:0] regVal,
    input wire logic [7:0] accumVal,
    output logic [7:0] diff,
    output logic carry,
    output logic digitCarry,
    output logic zero,
    output logic [7:0] swapped
);
    logic [8:0] fullSum;
    logic [4:0] lowSum;

    // Register plus inverted accumulator plus one: carry set means no borrow
    assign fullSum = {1'b0, regVal} + {1'b0, ~accumVal} + 9'h001;
    assign lowSum = {1'b0, regVal[3:0]} + {1'b0, ~accumVal[3:0]} + 5'h01;
    assign diff = fullSum[7:0];
    assign carry = fullSum[8];
    assign digitCarry = lowSum[4];
    assign zero = (fullSum[7:0] == 8'h00);
    // Nibble exchange
    assign swapped = {regVal[3:0], regVal[7:4]};
endmodule

// >>> src/msse_exec.sv
// APB-controlled executor for halt, SFR store, subtract and nibble swap
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
module msse_exec (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic haltMode,
    output logic [7:0] watchdogCounter,
    output logic [7:0] watchdogPrescaler
);
    logic [7:0] accumulator_ff;
    logic [7:0] fileReg_ff [msse_pkg::FILE_DEPTH];
    logic [7:0] sfrPage_ff [msse_pkg::SFR_DEPTH];
    logic carry_ff;
    logic digitCarry_ff;
    logic zero_ff;
    logic timeoutFlagN_ff;
    logic powerdownFlagN_ff;
    logic [7:0] wdog_ff;
    logic [7:0] wdogPre_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [7:0] op_ff;
    logic [6:0] addr_ff;
    logic dest_ff;
    msse_pkg::msse_state_t state_ff;
    msse_pkg::msse_state_t nxt_state;

    // Address decode
    logic setup;
    logic wrCmd;
    logic rdFile;
    logic rdSfr;
    logic hitFixed;
    logic mapped;
    logic [6:0] fileIdx;
    logic [4:0] sfrIdx;
    logic [7:0] statusByte;
    logic [31:0] nxt_prdata;

    assign setup = psel && !penable;
    assign fileIdx = paddr[6:0] >> 2;
    assign sfrIdx = paddr[6:2];
    assign rdFile = (paddr[7:6] == 2'b10) && (paddr[1:0] == 2'b00);
    assign rdSfr = (paddr[7:6] == 2'b11) && (paddr[1:0] == 2'b00);
    assign hitFixed = (paddr == msse_pkg::REG_CMD) || (paddr == msse_pkg::REG_ACCUM)
        || (paddr == msse_pkg::REG_STATUS) || (paddr == msse_pkg::REG_WATCHDOG);
    assign mapped = hitFixed || rdFile || rdSfr;
    assign wrCmd = setup && pwrite && (paddr == msse_pkg::REG_CMD) && (state_ff != msse_pkg::ST_EXEC);
    assign statusByte = {2'b00, (state_ff == msse_pkg::ST_SLEEP), timeoutFlagN_ff,
        powerdownFlagN_ff, zero_ff, digitCarry_ff, carry_ff};

    // Read mux; file window covers 16 words per APB page
    // Only the lower sixteen special-page entries are readable over the bus
    assign nxt_prdata = (paddr == msse_pkg::REG_ACCUM) ? {24'h000000, accumulator_ff} :
        (paddr == msse_pkg::REG_STATUS) ? {24'h000000, statusByte} :
        (paddr == msse_pkg::REG_WATCHDOG) ? {16'h0000, wdogPre_ff, wdog_ff} :
        rdFile ? {24'h000000, fileReg_ff[{3'b000, fileIdx[3:0]}]} :
        rdSfr ? {24'h000000, sfrPage_ff[{1'b0, sfrIdx[3:0]}]} : 32'h00000000;

    // Datapath
    logic [7:0] srcVal;
    logic [7:0] diff;
    logic [7:0] swapped;
    logic subC;
    logic subDigit;
    logic subZ;
    logic [7:0] result;
    logic isSub;
    logic isSwap;
    logic execNow;
    logic toAccum;
    logic toReg;

    assign srcVal = fileReg_ff[addr_ff];
    msse_alu u_alu (
        .regVal(srcVal),
        .accumVal(accumulator_ff),
        .diff(diff),
        .carry(subC),
        .digitCarry(subDigit),
        .zero(subZ),
        .swapped(swapped)
    );
    assign execNow = (state_ff == msse_pkg::ST_EXEC);
    assign isSub = execNow && (op_ff == msse_pkg::OP_SUB);
    assign isSwap = execNow && (op_ff == msse_pkg::OP_SWAP);
    assign result = isSub ? diff : swapped;
    assign toAccum = (isSub || isSwap) && !dest_ff;
    assign toReg = (isSub || isSwap) && dest_ff;

    // Next state: one execute cycle per command written in idle; commands written in halt never execute
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            msse_pkg::ST_IDLE: begin
                if (wrCmd) begin
                    nxt_state = msse_pkg::ST_EXEC;
                end
            end
            msse_pkg::ST_EXEC: begin
                nxt_state = (op_ff == msse_pkg::OP_HALT) ? msse_pkg::ST_SLEEP : msse_pkg::ST_IDLE;
            end
            msse_pkg::ST_SLEEP: begin
                // Only a wake command leaves halt
                if (wrCmd && (pwdata[7:0] == msse_pkg::OP_WAKE)) begin
                    nxt_state = msse_pkg::ST_IDLE;
                end
            end
            default: nxt_state = msse_pkg::ST_IDLE;
        endcase
    end

    // State and command latch
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= msse_pkg::ST_IDLE;
            op_ff <= 8'h00;
            addr_ff <= 7'h00;
            dest_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (wrCmd) begin
                op_ff <= pwdata[msse_pkg::CMD_OP_LSB +: 8];
                addr_ff <= pwdata[msse_pkg::CMD_ADDR_LSB +: 7];
                dest_ff <= pwdata[msse_pkg::CMD_DEST_BIT];
            end
        end
    end

    // APB answer: ready in the cycle after setup, so access phase lasts one edge
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            prdata_ff <= (setup && !pwrite) ? nxt_prdata : 32'h00000000;
        end
    end

    // Accumulator: software load or instruction write-back
    always_ff @(posedge clk) begin
        if (srst) begin
            accumulator_ff <= msse_pkg::ACCUM_RST;
        end else if (toAccum) begin
            // Write-back outranks a bus load; the bus cannot land in that cycle
            accumulator_ff <= result;
        end else if (setup && pwrite && (paddr == msse_pkg::REG_ACCUM)) begin
            accumulator_ff <= pwdata[7:0];
        end
    end

    // File registers; no reset keeps this a plain RAM
    always_ff @(posedge clk) begin
        if (toReg) begin
            fileReg_ff[addr_ff] <= result;
        end else if (setup && pwrite && rdFile) begin
            fileReg_ff[{3'b000, fileIdx[3:0]}] <= pwdata[7:0];
        end
    end

    // Special function page store
    always_ff @(posedge clk) begin
        if (execNow && (op_ff == msse_pkg::OP_SFR_STORE)) begin
            sfrPage_ff[addr_ff[4:0]] <= accumulator_ff;
        end
    end

    // Flags: only subtract touches arithmetic flags
    always_ff @(posedge clk) begin
        if (srst) begin
            carry_ff <= 1'b0;
            digitCarry_ff <= 1'b0;
            zero_ff <= 1'b0;
        end else if (isSub) begin
            carry_ff <= subC;
            digitCarry_ff <= subDigit;
            zero_ff <= subZ;
        end
    end

    // Watchdog and reset-cause flags
    always_ff @(posedge clk) begin
        if (srst) begin
            wdog_ff <= msse_pkg::WATCHDOG_CLEAR;
            wdogPre_ff <= msse_pkg::WATCHDOG_CLEAR;
            timeoutFlagN_ff <= 1'b1;
            powerdownFlagN_ff <= 1'b1;
        end else if (execNow && (op_ff == msse_pkg::OP_HALT)) begin
            // Both stages cleared together; counting resumes on the next edge
            wdog_ff <= msse_pkg::WATCHDOG_CLEAR;
            wdogPre_ff <= msse_pkg::WATCHDOG_CLEAR;
            timeoutFlagN_ff <= 1'b1;
            powerdownFlagN_ff <= 1'b0;
        end else begin
            // Prescaler free-runs and steps the counter on wrap
            wdogPre_ff <= wdogPre_ff + 8'h01;
            if (wdogPre_ff == 8'hff) begin
                wdog_ff <= wdog_ff + 8'h01;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    // One-hot sleep bit of the state flop drives the halt output directly
    assign haltMode = state_ff[2];
    assign watchdogCounter = wdog_ff;
    assign watchdogPrescaler = wdogPre_ff;
endmodule

// >>> tb/msse_exec_asserts.sv
// Checker for bus answers and halt entry
`timescale 1ns/100ps
module msse_exec_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic haltMode,
    input wire logic [7:0] watchdogCounter,
    input wire logic [7:0] watchdogPrescaler
);
    logic wakeReq;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Wake command at its setup edge
    assign wakeReq = psel && !penable && pwrite && paddr == 8'h00 && pwdata[7:0] == msse_pkg::OP_WAKE;
    sequence haltSeq;
        psel && !penable && pwrite && paddr == 8'h00 && pwdata[7:0] == msse_pkg::OP_HALT && !haltMode;
    endsequence
    sequence wdogClear;
        watchdogCounter == 8'h00 && watchdogPrescaler == 8'h00;
    endsequence
    ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
    upper_zero_a: assert property (pready && !pslverr |-> prdata[31:16] == 16'h0) else $error("upper bits");
    unmapped_err_a: assert property (psel && !penable && paddr == 8'h10 |=> pslverr) else $error("no error");
    halt_wdt_a: assert property (haltSeq |-> ##2 wdogClear) else $error("watchdog kept");
    halt_enter_a: assert property (haltSeq |-> ##2 haltMode) else $error("no halt");
    halt_hold_a: assert property (haltMode && !wakeReq && !$past(wakeReq) |=> haltMode) else $error("left halt");
    wake_leave_a: assert property (haltMode && wakeReq |=> !haltMode) else $error("stayed in halt");
endmodule
bind msse_exec msse_exec_asserts chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .haltMode(haltMode),
    .watchdogCounter(watchdogCounter), .watchdogPrescaler(watchdogPrescaler));

// >>> tb/msse_exec_test.sv
// Self-checking bench for the executor over APB
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module msse_exec_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic haltMode;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    logic [32:0] expQ[$];
    logic [32:0] e;
    logic [7:0] rnd = 8'h08;
    logic [7:0] accum, r, d, s;
    logic [5:0] st;
    msse_exec dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .haltMode(haltMode),
        .watchdogCounter(), .watchdogPrescaler());
    always #5 clk = ~clk;
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [7:0] fa(input int i);
        return msse_pkg::REG_FILE_BASE + 8'(i * 4);
    endfunction
    // Request held until ready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (!pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        expQ.push_back(x);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [6:0] ra, input logic dst);
        xfer(1'b1, msse_pkg::REG_CMD, {15'h0, dst, 1'b0, ra, op});
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Oldest note against each read answer
    always @(posedge clk) begin
        if (pready && !pwrite) begin
            e = expQ.pop_front();
            `CHK("read", e, {pslverr, prdata})
        end
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        accum = msse_pkg::ACCUM_RST;
        st = 6'h18;
        rd(msse_pkg::REG_STATUS, {27'h0, st});
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            accum = rnd;
            rnd = lfsr(rnd);
            r = (i == 3) ? accum : rnd; // Equal operands give zero
            xfer(1'b1, msse_pkg::REG_ACCUM, {24'h0, accum});
            xfer(1'b1, fa(i), {24'h0, r});
            cmd(msse_pkg::OP_SUB, 7'(i), i[0]);
            d = r - accum;
            st[2:0] = {d == 8'h00, r[3:0] >= accum[3:0], r >= accum};
            if (!i[0]) accum = d;
            else rd(fa(i), {25'h0, d});
            rd(msse_pkg::REG_ACCUM, {25'h0, accum});
            rd(msse_pkg::REG_STATUS, {27'h0, st});
            r = i[0] ? d : r;
            s = {r[3:0], r[7:4]};
            cmd(msse_pkg::OP_SWAP, 7'(i), i[1]);
            if (i[1]) rd(fa(i), {25'h0, s});
            else accum = s;
            cmd(msse_pkg::OP_SFR_STORE, 7'(i * 2), 1'b0);
            rd(msse_pkg::REG_SFR_BASE + 8'(i * 8), {25'h0, accum});
            rd(msse_pkg::REG_STATUS, {27'h0, st});
        end
        cmd(msse_pkg::OP_HALT, 7'h0, 1'b0);
        // Both stages cleared by halt; prescaler one step on at the read's setup edge
        rd(msse_pkg::REG_WATCHDOG, {17'h0, 8'h01, msse_pkg::WATCHDOG_CLEAR});
        st[5:3] = 3'b110;
        rd(msse_pkg::REG_STATUS, {27'h0, st});
        cmd(msse_pkg::OP_SWAP, 7'h0, 1'b0);
        rd(msse_pkg::REG_ACCUM, {25'h0, accum});
        // Wake leaves halt but keeps the reset-cause flags
        cmd(msse_pkg::OP_WAKE, 7'h0, 1'b0);
        st[5] = 1'b0;
        rd(msse_pkg::REG_STATUS, {27'h0, st});
        rd(8'h10, {1'b1, 32'h0});
        // Second reset in mid-run restores flags and accumulator
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(msse_pkg::REG_STATUS, {27'h0, 6'h18});
        rd(msse_pkg::REG_ACCUM, {25'h0, msse_pkg::ACCUM_RST});
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule
